// ---- hw/decode_pkg.sv ----
package decode_pkg;

  // Widths of the instruction stream and of the decoded fields.
  localparam int WORD_W = 16;
  localparam int FIELD_W = 4;
  localparam int MODE_W = 2;
  localparam int OPC_W = 5;
  localparam int SEG_W = 7;

  // Field positions inside the first instruction word.
  localparam int MODE_LSB = 14;
  localparam int OPC_LSB = 9;
  localparam int WB_POS = 8;
  localparam int SRC_LSB = 4;
  localparam int DST_LSB = 0;
  localparam int COND_LSB = 4;
  localparam int NUM_LSB = 0;
  localparam int RCNT_LSB = 4;

  // Field positions inside an extension word.
  localparam int INDEX_LSB = 8;
  localparam int LONG_FORM_POS = 15;
  localparam int SEG_LSB = 8;

  // Addressing mode field codes.
  localparam logic [1:0] MODE_IM_IR = 2'h0;
  localparam logic [1:0] MODE_DA_X = 2'h1;
  localparam logic [1:0] MODE_REG = 2'h2;

  // Source field value that marks the register-free forms.
  localparam logic [3:0] SRC_NONE = 4'h0;

  // Word/byte selector value for word-sized operands.
  localparam logic WB_WORD = 1'b1;

  // Condition field codes.
  localparam logic [3:0] CC_NEVER = 4'h0;
  localparam logic [3:0] CC_LT = 4'h1;
  localparam logic [3:0] CC_LE = 4'h2;
  localparam logic [3:0] CC_ULE = 4'h3;
  localparam logic [3:0] CC_WRAPPED = 4'h4;
  localparam logic [3:0] CC_MINUS = 4'h5;
  localparam logic [3:0] CC_ZERO = 4'h6;
  localparam logic [3:0] CC_CARRY = 4'h7;
  localparam logic [3:0] CC_ALWAYS = 4'h8;
  localparam logic [3:0] CC_GE = 4'h9;
  localparam logic [3:0] CC_GT = 4'ha;
  localparam logic [3:0] CC_UGT = 4'hb;
  localparam logic [3:0] CC_NOT_WRAPPED = 4'hc;
  localparam logic [3:0] CC_PLUS = 4'hd;
  localparam logic [3:0] CC_NONNULL = 4'he;
  localparam logic [3:0] CC_NO_CARRY = 4'hf;

  // Aliases that share an encoding with the codes above.
  localparam logic [3:0] CC_EQUAL = CC_ZERO;
  localparam logic [3:0] CC_UNEQUAL = CC_NONNULL;
  localparam logic [3:0] CC_UNSIGNED_BELOW = CC_CARRY;
  localparam logic [3:0] CC_UNSIGNED_AT_LEAST = CC_NO_CARRY;
  localparam logic [3:0] CC_EVEN_ONES = CC_WRAPPED;
  localparam logic [3:0] CC_ODD_ONES = CC_NOT_WRAPPED;

  // Displacement width selector.
  localparam logic [1:0] DISP_8 = 2'h0;
  localparam logic [1:0] DISP_12 = 2'h1;
  localparam logic [1:0] DISP_16 = 2'h2;

  // Decoded addressing kind reported to the datapath.
  typedef enum logic [2:0] {
    KIND_REGISTER,
    KIND_LITERAL,
    KIND_REG_POINTER,
    KIND_FIXED_LOCATION,
    KIND_OTHER
  } mode_kind_t;

endpackage

// ---- hw/cond_eval.sv ----
`timescale 1ns/10ps
module cond_eval (
  input wire logic [3:0] i_condition_field,
  input wire logic i_flag_zero,
  input wire logic i_flag_carry,
  input wire logic i_flag_sign,
  input wire logic i_flag_wrapped,
  input wire logic i_flag_parity,
  output logic o_holds
);

  logic sign_ne_wrap;
  logic le_term;

  // Shared signed terms keep the paired codes exact complements.
  assign sign_ne_wrap = i_flag_sign ^ i_flag_wrapped;
  assign le_term = i_flag_zero | sign_ne_wrap;

  // Flag test per condition code; aliases decode through the same item.
  always_comb begin
    unique case (i_condition_field)
      // RULE_01: never and always.
      decode_pkg::CC_NEVER: o_holds = 1'b0;
      decode_pkg::CC_ALWAYS: o_holds = 1'b1;
      // RULE_02: zero carry sign.
      // RULE_08: shared alias encodings.
      decode_pkg::CC_ZERO: o_holds = i_flag_zero;
      decode_pkg::CC_NONNULL: o_holds = ~i_flag_zero;
      decode_pkg::CC_CARRY: o_holds = i_flag_carry;
      decode_pkg::CC_NO_CARRY: o_holds = ~i_flag_carry;
      decode_pkg::CC_PLUS: o_holds = ~i_flag_sign;
      decode_pkg::CC_MINUS: o_holds = i_flag_sign;
      // RULE_03: overflow and parity. Parity and overflow share one flag bit
      // in the flag register, so both inputs are tied together upstream.
      decode_pkg::CC_WRAPPED: o_holds = i_flag_wrapped | i_flag_parity;
      decode_pkg::CC_NOT_WRAPPED: o_holds = ~(i_flag_wrapped | i_flag_parity);
      // RULE_04: signed ge/lt.
      decode_pkg::CC_GE: o_holds = ~sign_ne_wrap;
      decode_pkg::CC_LT: o_holds = sign_ne_wrap;
      // RULE_05: signed gt/le.
      decode_pkg::CC_GT: o_holds = ~le_term;
      decode_pkg::CC_LE: o_holds = le_term;
      // RULE_06: unsigned greater.
      decode_pkg::CC_UGT: o_holds = ~i_flag_carry & ~i_flag_zero;
      // RULE_07: unsigned less-or-equal.
      decode_pkg::CC_ULE: o_holds = i_flag_carry | i_flag_zero;
    endcase
  end

endmodule

// ---- hw/field_extract.sv ----
`timescale 1ns/10ps
module field_extract (
  input wire logic [15:0] i_word,
  input wire logic [15:0] i_ext_word,
  input wire logic [1:0] i_disp_width,
  output logic [1:0] o_mode,
  output logic [4:0] o_opcode_bits,
  output logic o_word_sel,
  output logic [3:0] o_src_field,
  output logic [3:0] o_dst_field,
  output logic [3:0] o_reg_count,
  output logic [3:0] o_num_field,
  output logic [3:0] o_condition_field,
  output logic [3:0] o_index_reg,
  output logic [15:0] o_displacement
);

  // RULE_09: fixed field slices.
  assign o_mode = i_word[decode_pkg::MODE_LSB +: decode_pkg::MODE_W];
  // RULE_12: remaining bits are opcode.
  assign o_opcode_bits = i_word[decode_pkg::OPC_LSB +: decode_pkg::OPC_W];
  assign o_word_sel = i_word[decode_pkg::WB_POS];
  assign o_src_field = i_word[decode_pkg::SRC_LSB +: decode_pkg::FIELD_W];
  assign o_dst_field = i_word[decode_pkg::DST_LSB +: decode_pkg::FIELD_W];
  assign o_reg_count = i_word[decode_pkg::RCNT_LSB +: decode_pkg::FIELD_W];
  assign o_num_field = i_word[decode_pkg::NUM_LSB +: decode_pkg::FIELD_W];
  assign o_condition_field = i_word[decode_pkg::COND_LSB +: decode_pkg::FIELD_W];
  // RULE_10: index register field.
  assign o_index_reg = i_ext_word[decode_pkg::INDEX_LSB +: decode_pkg::FIELD_W];

  // RULE_11: format-dependent displacement.
  // Short forms live in the first word and are sign extended to a word.
  always_comb begin
    unique case (i_disp_width)
      decode_pkg::DISP_8: o_displacement = {{8{i_word[7]}}, i_word[7:0]};
      decode_pkg::DISP_12: o_displacement = {{4{i_word[11]}}, i_word[11:0]};
      default: o_displacement = i_ext_word;
    endcase
  end

endmodule

// ---- hw/operand_decoder.sv ----
`timescale 1ns/10ps
// Behaviour
// RULE_01: One condition code never holds, one always holds, whatever the flags.
// RULE_02: Zero/not-zero test Z; carry/no-carry test C; plus/minus test S.
// RULE_03: Equal/unequal test Z; overflow codes test V; parity codes test P.
// RULE_04: Signed ge holds when S xor V is zero; lt when one.
// RULE_05: Signed gt holds when Z or (S xor V) is zero; le otherwise.
// RULE_06: Unsigned greater holds only with carry and zero both clear.
// RULE_07: Code 0011 is unsigned less-or-equal, holding when C or Z set.
// RULE_08: Equal/zero, unequal/nonzero, and other listed pairs evaluate identically.
// RULE_09: Extract 2-bit mode, 4-bit count, number, condition, one width bit.
// RULE_10: Based-indexed addressing takes a separate 4-bit index register field.
// RULE_11: Relative and based displacement width depends on instruction format.
// RULE_12: All other bits are opcode bits; nine basic layouts exist.
// RULE_13: Extension word count follows mode, immediate size and segmentation; the decoder fetches none for indexed and based forms.
// RULE_14: Mode 10 is register to register with no extension word.
// RULE_15: Mode 00 with zero source is immediate; word uses one word.
// RULE_16: Byte immediate word carries the same byte in both halves.
// RULE_17: Long immediate reads two words, high half first.
// RULE_18: Mode 00 with nonzero source is register pointer, no extension.
// RULE_19: Mode 01 zero source is direct; unsegmented takes one address word.
// RULE_20: Segmented short form: top bit 0, segment above, offset low byte.
// RULE_21: Segmented long form: top bit 1, then a full offset word.
// RULE_22: Width bit set means word, clear means byte, routed to datapath.
module operand_decoder (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_word_valid,
  input wire logic [15:0] i_word,
  output logic o_word_ready,
  input wire logic i_long_operand,
  input wire logic i_segmented,
  input wire logic [1:0] i_disp_width,
  input wire logic [3:0] i_condition_field,
  input wire logic i_flag_zero,
  input wire logic i_flag_carry,
  input wire logic i_flag_sign,
  input wire logic i_flag_wrapped,
  input wire logic i_flag_parity,
  output logic o_cond_holds,
  output logic o_dec_valid,
  output decode_pkg::mode_kind_t o_mode_kind,
  output logic [1:0] o_mode,
  output logic [4:0] o_opcode_bits,
  output logic o_is_word,
  output logic o_is_long,
  output logic [3:0] o_src_field,
  output logic [3:0] o_dst_field,
  output logic [3:0] o_reg_count,
  output logic [3:0] o_num_field,
  output logic [3:0] o_condition_field,
  output logic [3:0] o_index_reg,
  output logic [15:0] o_displacement,
  output logic [31:0] o_operand,
  output logic [6:0] o_segment,
  output logic [15:0] o_offset,
  output logic o_long_address,
  output logic [1:0] o_ext_count,
  output logic o_byte_mismatch
);

  typedef enum logic [2:0] {
    ST_FIRST,
    ST_EXT_A,
    ST_EXT_B,
    ST_EMIT
  } state_t;

  state_t state;
  state_t next_state;
  logic [15:0] first_word;
  logic [15:0] ext_a;
  logic take;
  logic [1:0] mode_f;
  logic [4:0] opc_f;
  logic wb_f;
  logic [3:0] src_f;
  logic [3:0] dst_f;
  logic [3:0] rcnt_f;
  logic [3:0] num_f;
  logic [3:0] cond_f;
  logic [3:0] index_f;
  logic [15:0] disp_f;
  logic cond_now;
  decode_pkg::mode_kind_t kind_now;
  decode_pkg::mode_kind_t kind;
  logic long_imm;

  // Condition evaluation against the live flags.
  cond_eval u_cond_eval (
    .i_condition_field(i_condition_field),
    .i_flag_zero(i_flag_zero),
    .i_flag_carry(i_flag_carry),
    .i_flag_sign(i_flag_sign),
    .i_flag_wrapped(i_flag_wrapped),
    .i_flag_parity(i_flag_parity),
    .o_holds(cond_now)
  );

  // Field slicing of the held first word and first extension word.
  field_extract u_field_extract (
    .i_word(first_word),
    .i_ext_word(ext_a),
    .i_disp_width(i_disp_width),
    .o_mode(mode_f),
    .o_opcode_bits(opc_f),
    .o_word_sel(wb_f),
    .o_src_field(src_f),
    .o_dst_field(dst_f),
    .o_reg_count(rcnt_f),
    .o_num_field(num_f),
    .o_condition_field(cond_f),
    .o_index_reg(index_f),
    .o_displacement(disp_f)
  );

  // The condition result is registered so the branch unit sees a clean level.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cond_holds <= 1'b0;
    end else begin
      o_cond_holds <= cond_now;
    end
  end

  // The fetch side may offer a word whenever no result is being emitted.
  assign o_word_ready = (state != ST_EMIT);
  assign take = i_word_valid & o_word_ready;

  // Addressing kind of the word being accepted in the first-word state.
  always_comb begin
    unique case (i_word[decode_pkg::MODE_LSB +: decode_pkg::MODE_W])
      // RULE_14: register to register.
      decode_pkg::MODE_REG: kind_now = decode_pkg::KIND_REGISTER;
      // RULE_15: immediate versus pointer.
      // RULE_18: nonzero source is pointer.
      decode_pkg::MODE_IM_IR: begin
        if (i_word[decode_pkg::SRC_LSB +: decode_pkg::FIELD_W] == decode_pkg::SRC_NONE) begin
          kind_now = decode_pkg::KIND_LITERAL;
        end else begin
          kind_now = decode_pkg::KIND_REG_POINTER;
        end
      end
      // RULE_19: direct address select.
      decode_pkg::MODE_DA_X: begin
        if (i_word[decode_pkg::SRC_LSB +: decode_pkg::FIELD_W] == decode_pkg::SRC_NONE) begin
          kind_now = decode_pkg::KIND_FIXED_LOCATION;
        end else begin
          kind_now = decode_pkg::KIND_OTHER;
        end
      end
      default: kind_now = decode_pkg::KIND_OTHER;
    endcase
  end

  // RULE_13: extension fetch sequencing.
  // Indexed and based forms fetch nothing here; their words pass through
  // the fetch unit, which knows the full format table.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_FIRST: begin
        if (take) begin
          if (kind_now == decode_pkg::KIND_LITERAL ||
              kind_now == decode_pkg::KIND_FIXED_LOCATION) begin
            next_state = ST_EXT_A;
          end else begin
            next_state = ST_EMIT;
          end
        end
      end
      ST_EXT_A: begin
        if (take) begin
          // RULE_17: long immediate second word.
          // RULE_21: long segmented offset word.
          if ((kind == decode_pkg::KIND_LITERAL && long_imm) ||
              (kind == decode_pkg::KIND_FIXED_LOCATION && i_segmented &&
               i_word[decode_pkg::LONG_FORM_POS])) begin
            next_state = ST_EXT_B;
          end else begin
            next_state = ST_EMIT;
          end
        end
      end
      ST_EXT_B: begin
        if (take) begin
          next_state = ST_EMIT;
        end
      end
      ST_EMIT: next_state = ST_FIRST;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_FIRST;
    end else begin
      state <= next_state;
    end
  end

  // Capture of the first word, its kind and the operand size.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_word <= 16'h0000;
      kind <= decode_pkg::KIND_OTHER;
      long_imm <= 1'b0;
    end else if (state == ST_FIRST && take) begin
      first_word <= i_word;
      kind <= kind_now;
      long_imm <= i_long_operand;
    end
  end

  // First extension word is kept for the index and displacement slices.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_a <= 16'h0000;
    end else if (state == ST_EXT_A && take) begin
      ext_a <= i_word;
    end
  end

  // Immediate operand assembly.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_operand <= 32'h0000_0000;
      o_byte_mismatch <= 1'b0;
    end else if (state == ST_FIRST && take) begin
      o_operand <= 32'h0000_0000;
      o_byte_mismatch <= 1'b0;
    end else if (kind == decode_pkg::KIND_LITERAL && take) begin
      if (state == ST_EXT_A) begin
        if (long_imm) begin
          // RULE_17: high half first.
          o_operand <= {i_word, 16'h0000};
        end else if (first_word[decode_pkg::WB_POS] == decode_pkg::WB_WORD) begin
          // RULE_15: single word operand.
          o_operand <= {16'h0000, i_word};
        end else begin
          // RULE_16: duplicated byte check.
          o_operand <= {24'h00_0000, i_word[7:0]};
          o_byte_mismatch <= (i_word[15:8] != i_word[7:0]);
        end
      end else if (state == ST_EXT_B) begin
        o_operand <= {o_operand[31:16], i_word};
      end
    end
  end

  // Direct address assembly.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_segment <= 7'h00;
      o_offset <= 16'h0000;
      o_long_address <= 1'b0;
    end else if (state == ST_FIRST && take) begin
      o_segment <= 7'h00;
      o_offset <= 16'h0000;
      o_long_address <= 1'b0;
    end else if (kind == decode_pkg::KIND_FIXED_LOCATION && take) begin
      if (state == ST_EXT_A) begin
        if (!i_segmented) begin
          // RULE_19: whole unsegmented address.
          o_offset <= i_word;
        end else begin
          o_segment <= i_word[decode_pkg::SEG_LSB +: decode_pkg::SEG_W];
          o_long_address <= i_word[decode_pkg::LONG_FORM_POS];
          // RULE_20: short segmented offset.
          o_offset <= {8'h00, i_word[7:0]};
        end
      end else if (state == ST_EXT_B) begin
        // RULE_21: long offset word.
        o_offset <= i_word;
      end
    end
  end

  // Extension words counted for the fetch unit's length bookkeeping.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_count <= 2'h0;
    end else if (state == ST_FIRST && take) begin
      o_ext_count <= 2'h0;
    end else if ((state == ST_EXT_A || state == ST_EXT_B) && take) begin
      o_ext_count <= o_ext_count + 2'h1;
    end
  end

  // Result publication: the field outputs change together with the valid pulse;
  // operand, address, extension count and byte mismatch update as each word is taken.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dec_valid <= 1'b0;
      o_mode_kind <= decode_pkg::KIND_OTHER;
      o_mode <= 2'h0;
      o_opcode_bits <= 5'h00;
      o_is_word <= 1'b0;
      o_is_long <= 1'b0;
      o_src_field <= 4'h0;
      o_dst_field <= 4'h0;
      o_reg_count <= 4'h0;
      o_num_field <= 4'h0;
      o_condition_field <= 4'h0;
      o_index_reg <= 4'h0;
      o_displacement <= 16'h0000;
    end else begin
      o_dec_valid <= (state == ST_EMIT);
      if (state == ST_EMIT) begin
        o_mode_kind <= kind;
        o_mode <= mode_f;
        o_opcode_bits <= opc_f;
        // RULE_22: operand width routing.
        o_is_word <= (wb_f == decode_pkg::WB_WORD);
        o_is_long <= long_imm;
        o_src_field <= src_f;
        o_dst_field <= dst_f;
        o_reg_count <= rcnt_f;
        o_num_field <= num_f;
        o_condition_field <= cond_f;
        o_index_reg <= index_f;
        o_displacement <= disp_f;
      end
    end
  end

endmodule

// ---- verif/decoder_checker.sv ----
`timescale 1ns/10ps
module decoder_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_condition_field,
  input wire logic i_flag_zero,
  input wire logic i_flag_carry,
  input wire logic i_flag_sign,
  input wire logic i_flag_wrapped,
  input wire logic o_word_ready,
  input wire logic o_cond_holds,
  input wire logic o_dec_valid,
  input wire decode_pkg::mode_kind_t o_mode_kind,
  input wire logic [1:0] o_mode,
  input wire logic o_is_long,
  input wire logic [3:0] o_src_field,
  input wire logic [1:0] o_ext_count
);
  // One clock domain, so reset is the only disable for every check.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // Each condition check ties the registered result to the code and flags sampled at the previous edge.
  never_false_a: assert property (i_condition_field == 4'h0 |=> !o_cond_holds)
    else $error("Never code held.");
  always_true_a: assert property (i_condition_field == 4'h8 |=> o_cond_holds)
    else $error("Always code did not hold.");
  zero_code_a: assert property (i_condition_field == 4'h6 |=> o_cond_holds == $past(i_flag_zero))
    else $error("Zero code wrong.");
  unsigned_le_a: assert property (i_condition_field == 4'h3 |=>
    o_cond_holds == ($past(i_flag_carry) | $past(i_flag_zero))) else $error("Code 3 wrong.");
  signed_ge_a: assert property (i_condition_field == 4'h9 |=>
    o_cond_holds != ($past(i_flag_sign) ^ $past(i_flag_wrapped))) else $error("Code 9 wrong.");
  signed_gt_a: assert property (i_condition_field == 4'ha |=>
    o_cond_holds != ($past(i_flag_zero) | ($past(i_flag_sign) ^ $past(i_flag_wrapped))))
    else $error("Code a wrong.");
  unsigned_gt_a: assert property (i_condition_field == 4'hb |=>
    o_cond_holds == (!$past(i_flag_carry) && !$past(i_flag_zero))) else $error("Code b wrong.");
  // The refusal cycle is always followed by exactly one result pulse.
  refuse_emit_a: assert property (!o_word_ready |=> o_dec_valid ##1 !o_dec_valid)
    else $error("Refusal not followed by one result.");
  reg_mode_a: assert property (o_dec_valid && o_mode == 2'h2 |->
    o_mode_kind == decode_pkg::KIND_REGISTER && o_ext_count == 2'h0) else $error("Bad register.");
  literal_mode_a: assert property (o_dec_valid && o_mode == 2'h0 && o_src_field == 4'h0 |->
    o_mode_kind == decode_pkg::KIND_LITERAL && o_ext_count == (o_is_long ? 2'h2 : 2'h1))
    else $error("Bad literal.");
  pointer_mode_a: assert property (o_dec_valid && o_mode == 2'h0 && o_src_field != 4'h0 |->
    o_mode_kind == decode_pkg::KIND_REG_POINTER && o_ext_count == 2'h0) else $error("Bad pointer.");
  fixed_mode_a: assert property (o_dec_valid && o_mode == 2'h1 && o_src_field == 4'h0 |->
    o_mode_kind == decode_pkg::KIND_FIXED_LOCATION && o_ext_count != 2'h0)
    else $error("Bad direct address.");
endmodule

bind operand_decoder decoder_checker u_chk (.i_clk_sys, .i_rst_n, .i_condition_field,
  .i_flag_zero, .i_flag_carry, .i_flag_sign, .i_flag_wrapped, .o_word_ready, .o_cond_holds,
  .o_dec_valid, .o_mode_kind, .o_mode, .o_is_long, .o_src_field, .o_ext_count);

// ---- verif/fetch_model.sv ----
`timescale 1ns/10ps
module fetch_model (
  input wire logic i_clk_sys,
  input wire logic i_word_ready,
  output logic o_word_valid,
  output logic [15:0] o_word
);
  initial begin
    o_word_valid = 1'b0;
    o_word = 16'h0000;
  end

  // whole word hold
  // Stall cycles scramble the idle bus so a stale word is never mistaken for data.
  task automatic send(input logic [15:0] w, input int stall);
    logic taken;
    repeat (stall) begin
      @(negedge i_clk_sys);
      o_word_valid = 1'b0;
      o_word = ~o_word;
    end
    @(negedge i_clk_sys);
    o_word_valid = 1'b1;
    o_word = w;
    taken = 1'b0;
    while (!taken) begin
      taken = (i_word_ready === 1'b1);
      @(posedge i_clk_sys);
      if (!taken) @(negedge i_clk_sys);
    end
  endtask

  // Releases the bus after the last word.
  task automatic rest();
    @(negedge i_clk_sys);
    o_word_valid = 1'b0;
    o_word = ~o_word;
  endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [15:0] w0;
    decode_pkg::mode_kind_t kind;
    logic [1:0] ext;
    logic [3:0] chk;
    logic [31:0] opd;
    logic [23:0] adr;
    logic [15:0] dsp;
    logic mis;
    logic [3:0] idx;
  } note_t;
  logic clk_sys, rst_n, word_valid, word_ready, long_operand, segmented, cond_holds, dec_valid;
  logic is_word, is_long, long_address, byte_mismatch, f_z, f_c, f_s, f_v;
  logic [15:0] word, displacement, offset, r, d;
  logic [1:0] disp_width, mode, ext_count;
  logic [3:0] cond, src, dst, rcnt, num, ccf, idx;
  logic [4:0] opc;
  logic [31:0] operand;
  logic [6:0] segment;
  decode_pkg::mode_kind_t kind;
  int miscompares, num_checks;
  note_t dq[$];
  note_t e;
  logic cq[$];

  operand_decoder u_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_word_valid(word_valid),
    .i_word(word), .o_word_ready(word_ready), .i_long_operand(long_operand),
    .i_segmented(segmented), .i_disp_width(disp_width), .i_condition_field(cond),
    .i_flag_zero(f_z), .i_flag_carry(f_c), .i_flag_sign(f_s), .i_flag_wrapped(f_v),
    .i_flag_parity(f_v), .o_cond_holds(cond_holds), .o_dec_valid(dec_valid),
    .o_mode_kind(kind), .o_mode(mode), .o_opcode_bits(opc), .o_is_word(is_word),
    .o_is_long(is_long), .o_src_field(src), .o_dst_field(dst), .o_reg_count(rcnt),
    .o_num_field(num), .o_condition_field(ccf), .o_index_reg(idx), .o_displacement(displacement),
    .o_operand(operand), .o_segment(segment), .o_offset(offset), .o_long_address(long_address),
    .o_ext_count(ext_count), .o_byte_mismatch(byte_mismatch));

  fetch_model u_fetch (.i_clk_sys(clk_sys), .i_word_ready(word_ready), .o_word_valid(word_valid),
    .o_word(word));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Flags are packed as zero, carry, sign, overflow; parity follows overflow on the pins.
  function automatic logic cexp(input logic [3:0] c, input logic [3:0] f);
    logic z, cy, s, v;
    {z, cy, s, v} = f;
    case (c)
      4'h0: return 1'b0;
      4'h1: return s ^ v;
      4'h2: return z | (s ^ v);
      4'h3: return cy | z;
      4'h4: return v;
      4'h5: return s;
      4'h6: return z;
      4'h7: return cy;
      4'h8: return 1'b1;
      4'h9: return !(s ^ v);
      4'ha: return !(z | (s ^ v));
      4'hb: return !cy && !z;
      4'hc: return !v;
      4'hd: return !s;
      4'he: return !z;
      default: return !cy;
    endcase
  endfunction

  task automatic cond_step(input logic [3:0] c, input logic [3:0] f);
    @(negedge clk_sys);
    cond = c;
    {f_z, f_c, f_s, f_v} = f;
    cq.push_back(cexp(c, f));
  endtask

  // Controls change by non-blocking assignment so they land after the edge that took a word.
  task automatic op(input logic [15:0] w0, w1, w2, input int n, input logic lng, seg,
      input decode_pkg::mode_kind_t k, input logic [3:0] chk, input logic [31:0] opd,
      input logic [23:0] adr, input logic mis);
    long_operand <= lng;
    segmented <= seg;
    dq.push_back('{w0, k, n[1:0], chk, opd, adr, {{4{w0[11]}}, w0[11:0]}, mis, w1[11:8]});
    u_fetch.send(w0, 0);
    if (n > 0) u_fetch.send(w1, n - 1);
    if (n > 1) u_fetch.send(w2, 3);
  endtask

  task automatic drain();
    u_fetch.rest();
    for (int k = 0; k < 50 && dq.size() > 0; k++) @(negedge clk_sys);
    if (dq.size() > 0) check("drain", 32'h1, 32'h0);
  endtask

  // The registered condition result is settled one edge after its inputs.
  always @(posedge clk_sys) begin
    if (cq.size() > 0) begin
      #1;
      check("cond_holds", cond_holds, cq.pop_front());
    end
  end

  // Each result pulse is matched with the oldest outstanding note.
  always @(negedge clk_sys) begin
    if (dec_valid === 1'b1) begin
      if (dq.size() == 0) check("spare_result", 32'h1, 32'h0);
      else begin
        e = dq.pop_front();
        check("kind", 32'(kind), 32'(e.kind));
        check("ext_count", ext_count, e.ext);
        check("fields", {mode, opc, is_word, src, dst, rcnt, num, ccf}, {e.w0, e.w0[7:0], e.w0[7:4]});
        if (e.chk[0]) check("operand", operand, e.opd);
        if (e.chk[1]) check("address", {long_address, segment, offset}, e.adr);
        if (e.chk[2]) check("displacement", displacement, e.dsp);
        if (e.chk[3]) check("byte_mismatch", byte_mismatch, e.mis);
        if (e.ext != 2'h0) check("index_reg", idx, e.idx);
        if (e.chk[1:0] == 2'h0 && e.ext != 2'h0) check("offset", offset, e.adr[15:0]);
      end
    end
  end

  // Whole run needs about four hundred and thirty cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    check("watchdog", 32'h1, 32'h0);
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    long_operand = 1'b0;
    segmented = 1'b0;
    disp_width = 2'h0;
    cond = 4'h0;
    {f_z, f_c, f_s, f_v} = 4'h0;
    void'($urandom(9));
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 256; i++) cond_step(i[7:4], i[3:0]);
    repeat (40) cond_step(4'($urandom), 4'($urandom));
    // Operations run back to back, so every next first word meets the refusal cycle.
    repeat (3) begin
      r = 16'($urandom);
      d = 16'($urandom);
      op({2'h2, r[13:0]}, 16'h0, 16'h0, 0, 0, 0, decode_pkg::KIND_REGISTER, 4'h0, 0, 0, 0);
      op({2'h0, r[13:9], 1'b1, 4'h0, r[3:0]}, d, 16'h0, 1, 0, 0, decode_pkg::KIND_LITERAL,
        4'h1, {16'h0, d}, 0, 0);
      op({2'h0, r[13:9], 1'b0, 4'h0, r[3:0]}, {2{d[7:0]}}, 16'h0, 1, 0, 0,
        decode_pkg::KIND_LITERAL, 4'h9, {24'h0, d[7:0]}, 0, 1'b0);
      op({2'h0, r[13:9], 1'b0, 4'h0, r[3:0]}, {~d[7:0], d[7:0]}, 16'h0, 1, 0, 0,
        decode_pkg::KIND_LITERAL, 4'h9, {24'h0, d[7:0]}, 0, 1'b1);
      op({2'h0, r[13:9], 1'b1, 4'h0, r[3:0]}, r, d, 2, 1, 0, decode_pkg::KIND_LITERAL,
        4'h1, {r, d}, 0, 0);
      op({2'h0, r[13:8], r[7:4] | 4'h1, r[3:0]}, 16'h0, 16'h0, 0, 0, 0,
        decode_pkg::KIND_REG_POINTER, 4'h0, 0, 0, 0);
      op({2'h1, r[13:8], 4'h0, r[3:0]}, d, 16'h0, 1, 0, 0, decode_pkg::KIND_FIXED_LOCATION,
        4'h0, 0, {8'h0, d}, 0);
      op({2'h1, r[13:8], 4'h0, r[3:0]}, {1'b0, d[14:8], r[7:0]}, 16'h0, 2'h1, 0, 1,
        decode_pkg::KIND_FIXED_LOCATION, 4'h2, 0, {1'b0, d[14:8], 8'h0, r[7:0]}, 0);
      op({2'h1, r[13:8], 4'h0, r[3:0]}, {1'b1, d[14:8], 8'h0}, r, 2, 0, 1,
        decode_pkg::KIND_FIXED_LOCATION, 4'h2, 0, {1'b1, d[14:8], r}, 0);
      op({2'h1, r[13:8], r[7:4] | 4'h1, r[3:0]}, 16'h0, 16'h0, 0, 0, 0,
        decode_pkg::KIND_OTHER, 4'h0, 0, 0, 0);
    end
    // Width is sampled at the result, so it only changes with the stream drained.
    for (int w = 0; w < 2; w++) begin
      drain();
      disp_width = w[1:0];
      r = 16'($urandom);
      if (w == 0) r[11:8] = {4{r[7]}};
      op({2'h3, r[13:0]}, 16'h0, 16'h0, 0, 0, 0, decode_pkg::KIND_OTHER, 4'h4, 0, 0, 0);
    end
    drain();
    close_out();
  end
endmodule
